/* sreq_pkg.sv */
// Package for the receive equalizer lane control block.
// Assumes a single core clock domain and an AXI4-Lite master outside.
package sreq_pkg;
	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int unsigned SERDES_NUM = 8;
	localparam int unsigned LANE_NUM   = 4;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] RXEQ_BASE     = 8'h00; // 8 words, 0x00..0x1c
	localparam logic [7:0] SLCTL_BASE    = 8'h20; // 8 words, 0x20..0x3c
	localparam logic [7:0] RESET_CTL_OFS = 8'h40; // Bit 0: soft reset pulse
	// ----------------------------------------
	// Field layout and reset values
	// ----------------------------------------
	localparam int unsigned ZERO_LSB  = 0;
	localparam int unsigned BOOST_LSB = 3;
	localparam int unsigned PICK_LSB  = 0;
	localparam logic [2:0] ZERO_RST   = 3'h1;
	localparam logic [2:0] BOOST_RST  = 3'h7;
	localparam logic [3:0] PICK_RST   = 4'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef logic [2:0] sreq_eq_t;
	// Boost sits above zero so the packed word matches the register bits
	typedef struct packed {
		sreq_eq_t boost;
		sreq_eq_t zero;
	} sreq_lane_s;
endpackage

/* sreq_wr_if.sv */
// Interface carrying a decoded register write to the lane store.
// Assumes both ends run on the core clock.
interface sreq_wr_if;
	logic       we;
	logic [2:0] serdes;
	logic [5:0] data;
	logic [3:0] pick;
	modport src (output we, output serdes, output data, output pick);
	modport dst (input we, input serdes, input data, input pick);
endinterface

/* sreq_lane_store.sv */
// Per-lane equalizer settings, kept through soft resets.
// Assumes only the fundamental reset i_arst_n clears the store.
module sreq_lane_store (
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_arst_n,
	sreq_wr_if.dst                     wr,
	output sreq_pkg::sreq_lane_s       o_lane [sreq_pkg::SERDES_NUM][sreq_pkg::LANE_NUM]
);
	sreq_pkg::sreq_lane_s store      [sreq_pkg::SERDES_NUM][sreq_pkg::LANE_NUM];
	sreq_pkg::sreq_lane_s next_store [sreq_pkg::SERDES_NUM][sreq_pkg::LANE_NUM];

	// Only picked lanes of the addressed serdes take the write
	always_comb begin
		next_store = store;
		for (int s = 0; s < int'(sreq_pkg::SERDES_NUM); s++) begin
			for (int l = 0; l < int'(sreq_pkg::LANE_NUM); l++) begin
				if (wr.we && (int'(wr.serdes) == s) && wr.pick[l]) begin
					next_store[s][l].zero  = wr.data[sreq_pkg::ZERO_LSB +: 3];
					next_store[s][l].boost = wr.data[sreq_pkg::BOOST_LSB +: 3];
				end
			end
		end
	end

	// No soft reset input: that is what keeps values sticky
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int s = 0; s < int'(sreq_pkg::SERDES_NUM); s++) begin
				for (int l = 0; l < int'(sreq_pkg::LANE_NUM); l++) begin
					store[s][l] <= '{zero: sreq_pkg::ZERO_RST, boost: sreq_pkg::BOOST_RST};
				end
			end
		end else begin
			store <= next_store;
		end
	end

	assign o_lane = store;
endmodule // sreq_lane_store

/* sreq_rx_eq_ctrl.sv */
// Receive equalizer lane control registers behind an AXI4-Lite slave.
// Assumes i_arst_n is the fundamental reset; soft reset comes by register.
//
// Notes on behaviour
// - Eight equalizer registers, one per serdes
// - Zero field bits 2:0, resets 0x1
// - Zero code rises with high-frequency gain
// - Boost field bits 5:3, resets 0x7
// - Boost code rises as low-frequency gain falls
// - Both fields zero turns equalization off
// - Writes touch only lanes picked by lane_pick
// - Lane values survive soft resets, all lanes
// - lane_pick is four bits wide
//
// Our own choices: the AXI4-Lite register port and the address map.
module sreq_rx_eq_ctrl (
	input  wire logic        i_sys_clk,
	input  wire logic        i_arst_n,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic [191:0]     o_eq_setting,
	output logic [31:0]      o_eq_enable
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	sreq_wr_if wr ();
	sreq_pkg::sreq_lane_s lane [sreq_pkg::SERDES_NUM][sreq_pkg::LANE_NUM];

	// Lowest set lane of a pick mask, 0 when none
	function automatic logic [1:0] first_lane(input logic [3:0] m);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (m[i]) r = 2'(i);
		end
		return r;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic       aw_held, next_aw_held, w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic [3:0] pick [sreq_pkg::SERDES_NUM];
	logic [3:0] next_pick [sreq_pkg::SERDES_NUM];
	logic       bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic [191:0] eq_set, next_eq_set;
	logic [31:0]  eq_en, next_eq_en;
	logic       do_wr;
	logic       awready, next_awready, wready, next_wready;
	logic       arready, next_arready;

	sreq_lane_store u_store (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.wr        (wr.dst),
		.o_lane    (lane)
	);

	// A write fires when both halves are held and no response waits
	assign do_wr = aw_held && w_held && !bvalid;

	// Route decoded equalizer writes to the lane store
	assign wr.we     = do_wr && (aw_addr[7:5] == sreq_pkg::RXEQ_BASE[7:5]) && w_strb[0];
	assign wr.serdes = aw_addr[4:2];
	assign wr.data   = w_data[5:0];
	assign wr.pick   = pick[aw_addr[4:2]];

	// Write channel, serdes control and soft reset
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_pick    = pick;
		if (!aw_held && i_awvalid) begin
			next_aw_held = 1'b1;
			next_aw_addr = i_awaddr;
		end
		if (!w_held && i_wvalid) begin
			next_w_held = 1'b1;
			next_w_data = i_wdata;
			next_w_strb = i_wstrb;
		end
		if (bvalid && i_bready) next_bvalid = 1'b0;
		if (do_wr) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = sreq_pkg::RESP_OKAY;
			if (aw_addr[7:5] == sreq_pkg::SLCTL_BASE[7:5]) begin
				if (w_strb[0]) next_pick[aw_addr[4:2]] = w_data[sreq_pkg::PICK_LSB +: 4];
			end else if (aw_addr == sreq_pkg::RESET_CTL_OFS) begin
				// Soft reset clears serdes control only; lane store is sticky
				if (w_strb[0] && w_data[0]) begin
					for (int s = 0; s < int'(sreq_pkg::SERDES_NUM); s++) next_pick[s] = sreq_pkg::PICK_RST;
				end
			end else if (aw_addr[7:5] != sreq_pkg::RXEQ_BASE[7:5]) begin
				next_bresp = sreq_pkg::RESP_SLVERR;
			end
		end
		// Ready is registered so the port comes straight from a flop
		next_awready = !next_aw_held;
		next_wready  = !next_w_held;
	end

	// Read channel; one read at a time, one cycle to answer
	always_comb begin
		next_rvalid = rvalid;
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (rvalid && i_rready) next_rvalid = 1'b0;
		if (!rvalid && i_arvalid) begin
			next_rvalid = 1'b1;
			next_rresp  = sreq_pkg::RESP_OKAY;
			next_rdata  = 32'h0;
			if (i_araddr[7:5] == sreq_pkg::RXEQ_BASE[7:5]) begin
				next_rdata[5:0] = lane[i_araddr[4:2]][first_lane(pick[i_araddr[4:2]])];
			end else if (i_araddr[7:5] == sreq_pkg::SLCTL_BASE[7:5]) begin
				next_rdata[3:0] = pick[i_araddr[4:2]];
			end else if (i_araddr != sreq_pkg::RESET_CTL_OFS) begin
				next_rresp = sreq_pkg::RESP_SLVERR;
			end
		end
		next_arready = !next_rvalid;
	end

	// Analog-facing settings, one 6-bit word and enable per lane
	always_comb begin
		next_eq_set = '0;
		next_eq_en  = '0;
		for (int s = 0; s < int'(sreq_pkg::SERDES_NUM); s++) begin
			for (int l = 0; l < int'(sreq_pkg::LANE_NUM); l++) begin
				// Codes pass straight: zero rises with HF gain, boost cuts LF gain
				next_eq_set[(s*4+l)*6 +: 6] = {lane[s][l].boost, lane[s][l].zero};
				next_eq_en[s*4+l] = (lane[s][l] != '0);
			end
		end
	end

	// Registers, reset by the fundamental reset; soft reset also clears pick
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held  <= 1'b0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= 2'h0;
			rvalid  <= 1'b0;
			rresp   <= 2'h0;
			rdata   <= 32'h0;
			// Mirror the store's reset codes so no lane reads as off in reset
			eq_set  <= {(sreq_pkg::SERDES_NUM * sreq_pkg::LANE_NUM){sreq_pkg::BOOST_RST, sreq_pkg::ZERO_RST}};
			eq_en   <= '1;
			awready <= 1'b1;
			wready  <= 1'b1;
			arready <= 1'b1;
			for (int s = 0; s < int'(sreq_pkg::SERDES_NUM); s++) pick[s] <= sreq_pkg::PICK_RST;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held  <= next_w_held;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rresp   <= next_rresp;
			rdata   <= next_rdata;
			eq_set  <= next_eq_set;
			eq_en   <= next_eq_en;
			pick    <= next_pick;
			awready <= next_awready;
			wready  <= next_wready;
			arready <= next_arready;
		end
	end

	// Ready is low while a channel is held, giving back-pressure
	assign o_awready    = awready;
	assign o_wready     = wready;
	assign o_bvalid     = bvalid;
	assign o_bresp      = bresp;
	assign o_arready    = arready;
	assign o_rvalid     = rvalid;
	assign o_rresp      = rresp;
	assign o_rdata      = rdata;
	assign o_eq_setting = eq_set;
	assign o_eq_enable  = eq_en;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	wr_pick_only_a : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		wr.we && !wr.pick[0] |=> lane[$past(wr.serdes)][0] == $past(lane[wr.serdes][0]))
		else $error("unpicked lane 0 changed");
	wr_pick_take_a : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		wr.we && wr.pick[3] |=> lane[$past(wr.serdes)][3] == $past(wr.data))
		else $error("picked lane 3 not written");
	eq_off_a : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		lane[7][3] == '0 |=> !o_eq_enable[31])
		else $error("equalizer left on at zero codes");
	eq_on_a : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		lane[7][3] != '0 |=> o_eq_enable[31])
		else $error("equalizer off at nonzero codes");
	set_map_a : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		1'b1 |=> o_eq_setting[5:0] == $past({lane[0][0].boost, lane[0][0].zero}))
		else $error("setting field order wrong");
	rd_upper_a : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_rvalid |-> o_rdata[31:6] == 26'h0)
		else $error("upper read bits not zero");
	rd_answer_a : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arvalid && o_arready |=> o_rvalid)
		else $error("read answer late");
	soft_sticky_a : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		do_wr && aw_addr == sreq_pkg::RESET_CTL_OFS && !wr.we |=> lane[0][0] == $past(lane[0][0]))
		else $error("soft reset disturbed lane store");
	pick_wr_a : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		do_wr && aw_addr[7:5] == sreq_pkg::SLCTL_BASE[7:5] && w_strb[0]
		|=> pick[$past(aw_addr[4:2])] == $past(w_data[3:0]))
		else $error("lane_pick not stored");
endmodule // sreq_rx_eq_ctrl

/* serdes_rx_eq_lane_control_test.sv */
// Self-checking bench for the receive equalizer lane control block.
// Assumes the AXI4-Lite slave and the register map of sreq_pkg.
module serdes_rx_eq_lane_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic         i_sys_clk = 1'b0;
	logic         i_arst_n;
	logic [7:0]   i_awaddr, i_araddr;
	logic [31:0]  i_wdata;
	logic [3:0]   i_wstrb;
	logic         i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0]   o_bresp, o_rresp;
	logic [31:0]  o_rdata, o_eq_enable;
	logic [191:0] o_eq_setting;
	int           error_cnt = 0;
	int           num_checks = 0;
	int           cyc = 0;
	localparam logic [7:0] EQ = sreq_pkg::RXEQ_BASE;
	localparam logic [7:0] PK = sreq_pkg::SLCTL_BASE;

	sreq_rx_eq_ctrl u_sreq_rx_eq_ctrl (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
		.i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
		.i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
		.o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
		.o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
		.o_eq_setting(o_eq_setting), .o_eq_enable(o_eq_enable));

	// ----------------------------------------
	// Clock, timeout and reporting
	// ----------------------------------------
	always #12.5 i_sys_clk = ~i_sys_clk;
	// Whole run needs about a hundred cycles; ceiling leaves ample slack
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// Address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge i_sys_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(posedge i_sys_clk);
			if (!aw_ok && o_awready) begin
				aw_ok = 1'b1;
				i_awvalid <= 1'b0;
			end
			if (!w_ok && o_wready) begin
				w_ok = 1'b1;
				i_wvalid <= 1'b0;
			end
		end while (!(aw_ok && w_ok));
		while (!o_bvalid) @(posedge i_sys_clk);
		r = o_bresp;
		i_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_sys_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do @(posedge i_sys_clk); while (!o_arready);
		i_arvalid <= 1'b0;
		do @(posedge i_sys_clk); while (!o_rvalid);
		d = o_rdata;
		r = o_rresp;
		i_rready <= 1'b0;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		repeat (2) @(posedge i_sys_clk);
		for (int l = 0; l < 32; l++) chk(32'(o_eq_setting[l*6+:6]), 32'h39);
		chk(o_eq_enable, 32'hffffffff);
		for (int s = 0; s < 8; s++) begin
			rd(EQ + 8'(4*s), d, r);
			chk(d, 32'h39);
			chk(32'(r), 32'(sreq_pkg::RESP_OKAY));
		end
		$display("test reset values done");
	endtask
	// Lanes 1 and 2 of serdes 2 picked; upper bits written as ones
	task automatic t_pick();
		logic [31:0] d;
		logic [1:0]  r;
		wr(PK + 8'h08, 32'hfffffff6, r);
		rd(PK + 8'h08, d, r);
		chk(d, 32'h6);
		wr(EQ + 8'h08, 32'hffffffea, r);
		rd(EQ + 8'h08, d, r);
		chk(d, 32'h2a);
		repeat (2) @(posedge i_sys_clk);
		for (int i = 0; i < 4; i++) chk(32'(o_eq_setting[(8+i)*6+:6]), (i == 1 || i == 2) ? 32'h2a : 32'h39);
		// Byte 0 strobe low: the picked lanes must keep their codes
		i_wstrb <= 4'he;
		wr(EQ + 8'h08, 32'h0, r);
		i_wstrb <= 4'hf;
		rd(EQ + 8'h08, d, r);
		chk(d, 32'h2a);
		$display("test lane pick done");
	endtask
	// Both codes zero on lane 3 of serdes 7, then one code nonzero
	task automatic t_off();
		logic [1:0] r;
		wr(PK + 8'h1c, 32'h8, r);
		wr(EQ + 8'h1c, 32'h0, r);
		repeat (2) @(posedge i_sys_clk);
		chk(o_eq_enable, 32'h7fffffff);
		wr(EQ + 8'h1c, 32'h08, r);
		repeat (2) @(posedge i_sys_clk);
		chk(o_eq_enable, 32'hffffffff);
		$display("test equalizer off done");
	endtask
	// Soft reset clears picks but keeps every lane's values
	task automatic t_soft();
		logic [31:0] d;
		logic [1:0]  r;
		wr(sreq_pkg::RESET_CTL_OFS, 32'h1, r);
		rd(PK + 8'h08, d, r);
		chk(d, 32'h0);
		wr(EQ + 8'h08, 32'h3f, r);
		rd(EQ + 8'h08, d, r);
		chk(d, 32'h39);
		repeat (2) @(posedge i_sys_clk);
		chk(32'(o_eq_setting[9*6+:6]), 32'h2a);
		chk(32'(o_eq_setting[31*6+:6]), 32'h08);
		$display("test soft reset done");
	endtask
	task automatic t_unmap();
		logic [31:0] d;
		logic [1:0]  r;
		wr(8'h80, 32'h1, r);
		chk(32'(r), 32'(sreq_pkg::RESP_SLVERR));
		rd(8'h80, d, r);
		chk(32'(r), 32'(sreq_pkg::RESP_SLVERR));
		chk(d, 32'h0);
		$display("test unmapped address done");
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		i_arst_n = 1'b0;
		i_awaddr = 8'h00;
		i_araddr = 8'h00;
		i_wdata = 32'h0;
		i_wstrb = 4'hf;
		i_awvalid = 1'b0;
		i_wvalid = 1'b0;
		i_bready = 1'b0;
		i_arvalid = 1'b0;
		i_rready = 1'b0;
		repeat (3) @(posedge i_sys_clk);
		i_arst_n <= 1'b1;
		t_reset();
		t_pick();
		t_off();
		t_soft();
		t_unmap();
		complete_run();
	end
endmodule // serdes_rx_eq_lane_control_test
